// >>> hw/mopp_pkg.sv
/*
  Constants for the media payload packer: command dword layout,
  packing geometry, modes and state codes.
  Assumes the command parser hands over whole command dwords in order.
*/
package mopp_pkg;

  // command dword positions
  localparam int unsigned HDR_LEN_DW  = 0;
  localparam int unsigned HDR_ILEN_DW = 2;
  localparam int unsigned HDR_ADDR_DW = 3;

  // dword length field of dword 0
  localparam int unsigned DWLEN_W     = 8;
  localparam logic [7:0]  LEN_BIAS    = 8'h02;

  // indirect length field, bits 16:0 of dword 2
  localparam int unsigned ILEN_W      = 17;

  // payload register geometry
  localparam int unsigned DW_PER_REG  = 8;
  localparam int unsigned REG_IDX_W   = 6;

  // buffer in the command path
  localparam int unsigned FIFO_DEPTH  = 16;

  // reset values
  localparam logic [31:0] RST_WORD    = 32'h0000_0000;

  // operating modes
  typedef enum logic [1:0] {
    MODE_PASS = 2'b00,
    MODE_COEF = 2'b01,
    MODE_BITS = 2'b10
  } mopp_mode_e;

  // packer states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_HDR   = 3'b001,
    ST_INL   = 3'b010,
    ST_FETCH = 3'b011,
    ST_IND   = 3'b100
  } mopp_state_e;

endpackage

// >>> hw/mopp_packer.sv
/*
  Media payload packer: takes the trailing fields of a media dispatch
  command and writes inline then indirect dwords into 8-dword payload
  registers, zero padding each partial register. Holds the command
  buffer module and the packer.
  Assumes the command parser, the indirect fetch unit and the return
  buffer all run on clk_sys and use valid/ready handshakes.
*/

////////////////////////////////////////////////////////////////////////
// command dword buffer

module mopp_fifo #(
  parameter int unsigned W = 32,
  parameter int unsigned D = 16
) (
  input  wire logic         clk_sys,
  input  wire logic         rstn,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int unsigned AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
    logic                room;
  } mopp_fifo_s;

  mopp_fifo_s st;
  mopp_fifo_s next_st;
  logic       push;
  logic       pop;

  // pointer and count update; room is kept as a flop for a clean ready
  always_comb begin
    next_st = st;
    push = in_valid && st.room;
    pop = st.cnt != '0 && out_ready;
    if (push) begin
      next_st.mem[st.wp] = in_data;
      next_st.wp = (st.wp == AW'(D - 1)) ? '0 : st.wp + 1'b1;
    end
    if (pop) begin
      next_st.rp = (st.rp == AW'(D - 1)) ? '0 : st.rp + 1'b1;
    end
    next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
    next_st.room = next_st.cnt != (AW+1)'(D);
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
      st.room <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign in_ready = st.room;
  assign out_valid = st.cnt != '0;
  assign out_data = st.mem[st.rp];

  // ready drops only when every slot holds a word
  fifo_room_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    !in_ready |-> st.cnt == (AW+1)'(D))
    else $error("fifo refuses data while not full");

endmodule

////////////////////////////////////////////////////////////////////////
// payload packer
//
// Function
// RULE_01: dword 3 is indirect address over base
// RULE_02: no indirect data means address ignored
// RULE_03: bitstream mode address may be byte aligned
// RULE_04: other modes give dword aligned address
// RULE_05: software keeps address below 512MB
// RULE_06: indirect length is 17-bit byte count
// RULE_07: inline data starts at command dword 4
// RULE_08: coefficient and bitstream modes parse inline format
// RULE_09: pass-through forwards inline dwords unchanged
// RULE_10: software keeps total within buffer allocation
// RULE_11: pass-through commands always carry inline data
// RULE_12: length field N+2 means N inline dwords
// RULE_13: inline data fills whole 8-dword registers
// RULE_14: N multiple of eight writes N/8 registers
// RULE_15: otherwise N/8+1 registers, last zero padded
// RULE_16: indirect registers follow last inline register
// RULE_17: last indirect register is zero padded
// RULE_18: zero indirect length disables fetch entirely
// RULE_19: software limits indirect to 496 dwords, 62 registers
// RULE_20: one command finishes before next payload starts
module mopp_packer (
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic [1:0]  mode,
  input  wire logic [31:0] ind_base,
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  input  wire logic [31:0] cmd_data,
  output logic             fetch_req,
  output logic [31:0]      fetch_addr,
  output logic [16:0]      fetch_bytes,
  input  wire logic        ind_valid,
  output logic             ind_ready,
  input  wire logic [31:0] ind_data,
  output logic             wr_valid,
  input  wire logic        wr_ready,
  output logic [255:0]     wr_data,
  output logic [5:0]       wr_index,
  output logic             wr_last,
  output logic [31:0]      inl_ctrl,
  output logic             busy
);

  typedef struct packed {
    mopp_pkg::mopp_state_e state;
    logic [1:0]            hdr_cnt;
    logic [7:0]            n_inl;
    logic [7:0]            inl_left;
    logic [16:0]           ind_len;
    logic [31:0]           ind_addr;
    logic [15:0]           ind_left;
    logic [2:0]            slot;
    logic [7:0][31:0]      acc;
    logic [5:0]            reg_cnt;
    logic                  wr_valid;
    logic [255:0]          wr_data;
    logic [5:0]            wr_index;
    logic [3:0]            wr_fill;
    logic                  wr_last;
    logic                  ind_rdy;
    logic                  fetch_req;
    logic [31:0]           fetch_addr;
    logic [16:0]           fetch_bytes;
    logic [31:0]           inl_ctrl;
    logic                  busy;
  } mopp_st_s;

  mopp_st_s    st;
  mopp_st_s    next_st;
  logic        f_valid;
  logic        f_ready;
  logic [31:0] f_data;

  // command dwords wait here; cmd_ready is the buffer's registered room
  mopp_fifo #(
    .W (32),
    .D (mopp_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .rstn      (rstn),
    .in_valid  (cmd_valid),
    .in_ready  (cmd_ready),
    .in_data   (cmd_data),
    .out_valid (f_valid),
    .out_ready (f_ready),
    .out_data  (f_data)
  );

  // byte count to dword count, rounded up
  function automatic logic [15:0] dw_of_bytes(input logic [16:0] b);
    logic [17:0] t;
    t = {1'b0, b} + 18'h00003;
    return t[17:2];
  endfunction

  // dword count to register count, rounded up
  function automatic logic [5:0] regs_of_dw(input logic [7:0] n);
    logic [8:0] t;
    t = {1'b0, n} + 9'h007;
    return t[8:3];
  endfunction

  // place one dword; close the register when full or at phase end
  function automatic mopp_st_s pack(input mopp_st_s s,
                                    input logic [31:0] d,
                                    input logic endp,
                                    input logic lastc);
    mopp_st_s r;
    r = s;
    r.acc[s.slot] = d;
    if (s.slot == 3'h7 || endp) begin
      r.wr_valid = 1'b1;
      r.wr_data = r.acc;
      r.wr_index = s.reg_cnt;
      r.wr_fill = {1'b0, s.slot} + 4'h1;
      r.wr_last = lastc;
      r.reg_cnt = s.reg_cnt + 6'h01;
      r.acc = '0; // unused dwords of the next register read as zero
      r.slot = 3'h0;
    end else begin
      r.slot = s.slot + 3'h1;
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    logic       can_take;
    logic       take_ind;
    logic [7:0] n;
    can_take = 1'b0;
    take_ind = 1'b0;
    n = 8'h00;
    next_st = st;
    f_ready = 1'b0;
    next_st.fetch_req = 1'b0;
    if (st.wr_valid && wr_ready) begin
      next_st.wr_valid = 1'b0;
    end
    // a new register may close only when the output slot is free
    can_take = !st.wr_valid || wr_ready;
    case (st.state)
      mopp_pkg::ST_IDLE: begin
        f_ready = 1'b1;
        if (f_valid) begin
          // length field N+2 gives N inline dwords
          n = (f_data[7:0] > mopp_pkg::LEN_BIAS) ?
              f_data[7:0] - mopp_pkg::LEN_BIAS : 8'h00; // RULE_12
          next_st.n_inl = n;
          next_st.inl_left = n;
          next_st.hdr_cnt = 2'h1;
          next_st.reg_cnt = 6'h00;
          next_st.slot = 3'h0;
          next_st.acc = '0;
          next_st.state = mopp_pkg::ST_HDR;
        end
      end
      mopp_pkg::ST_HDR: begin
        f_ready = 1'b1;
        if (f_valid) begin
          next_st.hdr_cnt = st.hdr_cnt + 2'h1;
          if (st.hdr_cnt == 2'(mopp_pkg::HDR_ILEN_DW)) begin
            next_st.ind_len = f_data[mopp_pkg::ILEN_W-1:0]; // RULE_06
          end
          if (st.hdr_cnt == 2'(mopp_pkg::HDR_ADDR_DW)) begin
            next_st.ind_addr = f_data; // RULE_01
            next_st.ind_left = dw_of_bytes(st.ind_len); // RULE_06
            // next dword is command dword 4, the first inline one
            if (st.inl_left != 8'h00) begin
              next_st.state = mopp_pkg::ST_INL; // RULE_07
            end else if (st.ind_len != '0) begin
              next_st.state = mopp_pkg::ST_FETCH;
            end else begin
              next_st.state = mopp_pkg::ST_IDLE; // RULE_02 RULE_18
            end
          end
        end
      end
      mopp_pkg::ST_INL: begin
        f_ready = can_take;
        if (f_valid && can_take) begin
          // dwords go out untouched in every mode
          next_st = pack(next_st, f_data, st.inl_left == 8'h01,
                         st.ind_len == '0); // RULE_09 RULE_13
          next_st.inl_left = st.inl_left - 8'h01;
          if (mode != mopp_pkg::MODE_PASS && st.inl_left == st.n_inl) begin
            next_st.inl_ctrl = f_data; // RULE_08
          end
          if (st.inl_left == 8'h01) begin
            next_st.state = (st.ind_len != '0) ? mopp_pkg::ST_FETCH :
                            mopp_pkg::ST_IDLE; // RULE_18
          end
        end
      end
      mopp_pkg::ST_FETCH: begin
        // address is taken relative to the indirect base
        next_st.fetch_req = 1'b1;
        next_st.fetch_addr = ind_base + st.ind_addr; // RULE_01
        next_st.fetch_bytes = st.ind_len;
        next_st.state = mopp_pkg::ST_IND; // RULE_16
      end
      mopp_pkg::ST_IND: begin
        take_ind = st.ind_rdy && ind_valid;
        if (take_ind) begin
          next_st = pack(next_st, ind_data, st.ind_left == 16'h0001,
                         st.ind_left == 16'h0001); // RULE_17
          next_st.ind_left = st.ind_left - 16'h0001;
          if (st.ind_left == 16'h0001) begin
            next_st.state = mopp_pkg::ST_IDLE; // RULE_20
          end
        end
      end
      default: begin
        next_st.state = mopp_pkg::ST_IDLE;
      end
    endcase
    // indirect ready is registered: high only while a close cannot stall
    next_st.ind_rdy = next_st.state == mopp_pkg::ST_IND && !next_st.wr_valid
                      && !(take_ind && st.ind_left == 16'h0001);
    next_st.busy = next_st.state != mopp_pkg::ST_IDLE || next_st.wr_valid;
  end

  ////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // outputs come straight from the state register
  assign fetch_req = st.fetch_req;
  assign fetch_addr = st.fetch_addr;
  assign fetch_bytes = st.fetch_bytes;
  assign ind_ready = st.ind_rdy;
  assign wr_valid = st.wr_valid;
  assign wr_data = st.wr_data;
  assign wr_index = st.wr_index;
  assign wr_last = st.wr_last;
  assign inl_ctrl = st.inl_ctrl;
  assign busy = st.busy;

  ////////////////////////////////////////////////////////////////////
  // checks

  sequence s_stall;
    st.wr_valid && !wr_ready;
  endsequence

  sequence s_leave_inl;
    $fell(st.state == mopp_pkg::ST_INL);
  endsequence

  // a stalled register holds its contents
  hold_data_a: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE_13
    s_stall |=> st.wr_valid && $stable(st.wr_data) && $stable(st.wr_index))
    else $error("payload register changed while stalled");

  // inline phase closes ceil(N/8) registers
  inl_regs_a: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE_15
    s_leave_inl |-> st.reg_cnt == regs_of_dw(st.n_inl))
    else $error("wrong inline register count");

  // indirect registers are numbered right after the inline ones
  ind_follow_a: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE_16
    $rose(st.state == mopp_pkg::ST_IND) |-> st.reg_cnt == regs_of_dw(st.n_inl))
    else $error("indirect data does not follow inline data");

  // dwords past the fill level of a register are zero
  pad_zero_a: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE_17
    st.wr_valid && st.wr_fill < 4'h8 |-> (st.wr_data >> (32 * st.wr_fill)) == '0)
    else $error("partial register not zero padded");

  // a fetch is only issued for a nonzero length
  fetch_len_a: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE_18
    st.fetch_req |-> st.fetch_bytes != '0 && st.fetch_bytes == st.ind_len ##1 !st.fetch_req)
    else $error("bad indirect fetch request");

  // the fetch address is base plus the command offset
  fetch_addr_a: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE_01
    st.fetch_req |-> st.fetch_addr == $past(ind_base) + st.ind_addr)
    else $error("fetch address not offset from base");

  // inline count is the length field less two
  inl_size_a: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE_12
    $rose(st.state == mopp_pkg::ST_HDR) && $past(f_data[7:0]) > 8'h02
    |-> st.n_inl == $past(f_data[7:0]) - 8'h02)
    else $error("inline size not derived from length field");

  // a register still waiting in idle is the last one of its command
  one_cmd_a: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE_20
    st.state == mopp_pkg::ST_IDLE && st.wr_valid |-> st.wr_last || !st.busy)
    else $error("payload of two commands interleaved");

  // non pass-through modes capture the first inline dword
  parse_a: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE_08
    st.state == mopp_pkg::ST_INL && f_valid && f_ready && mode != 2'b00 &&
    st.inl_left == st.n_inl |=> st.inl_ctrl == $past(f_data))
    else $error("inline control word not captured");

endmodule

// >>> tb/mopp_partner.sv
/*
  Far side of the payload packer: indirect fetch unit and return buffer.
  Assumes one clock clk_sys and valid/ready handshakes on both paths.
*/
module mopp_partner (
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic        slow,
  input  wire logic        hold_wr,
  input  wire logic        fetch_req,
  input  wire logic [31:0] fetch_addr,
  input  wire logic [16:0] fetch_bytes,
  output logic             ind_valid,
  input  wire logic        ind_ready,
  output logic [31:0]      ind_data,
  input  wire logic        wr_valid,
  output logic             wr_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] fa;
  logic [15:0] left;
  logic [15:0] k;
  logic [15:0] next_left;
  logic [7:0]  cyc;

  //////////////////////////////////////////////////////////////////////
  // dwords still owed for the current fetch
  always_comb begin
    next_left = fetch_req ? 16'((fetch_bytes + 17'h3) >> 2)
                          : left - 16'(ind_valid && ind_ready);
  end

  // offer dwords, with gaps when slow, holding each until taken
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      fa        <= 32'h0;
      left      <= 16'h0;
      k         <= 16'h0;
      cyc       <= 8'h0;
      ind_valid <= 1'b0;
    end else begin
      cyc  <= cyc + 8'h1;
      left <= next_left;
      if (fetch_req) begin
        fa <= fetch_addr;
        k  <= 16'h0;
      end else if (ind_valid && ind_ready) begin
        k <= k + 16'h1;
      end
      if (!(ind_valid && !ind_ready)) begin
        ind_valid <= (next_left != 16'h0) && !(slow && cyc[1]);
      end
    end
  end

  // released data line shows the inverted pattern
  assign ind_data = ind_valid ? {fa[15:0], k} : ~{fa[15:0], k};
  assign wr_ready = !hold_wr && !(slow && cyc[2]);
endmodule

// >>> tb/testbench.sv
/*
  Self-checking bench for the payload packer: sends commands, predicts
  payload registers and fetches.
  Assumes the partner model answers fetches and return buffer writes.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, rstn, slow, hold_wr, saw_full;
  logic [1:0] mode;
  logic [31:0] ind_base, cmd_data, fetch_addr, ind_data, inl_ctrl;
  logic cmd_valid, cmd_ready, fetch_req, ind_valid, ind_ready;
  logic wr_valid, wr_ready, wr_last, busy;
  logic [16:0] fetch_bytes;
  logic [255:0] wr_data;
  logic [5:0] wr_index;
  logic [262:0] exp_q[$];
  logic [48:0] fq[$];
  logic [262:0] e;
  logic [48:0] f;
  int mismatches, samples_checked;
  logic [7:0] cmd_no;

  mopp_packer i_mopp_packer (.clk_sys, .rstn, .mode, .ind_base, .cmd_valid, .cmd_ready,
    .cmd_data, .fetch_req, .fetch_addr, .fetch_bytes, .ind_valid, .ind_ready, .ind_data,
    .wr_valid, .wr_ready, .wr_data, .wr_index, .wr_last, .inl_ctrl, .busy);
  mopp_partner i_mopp_partner (.clk_sys, .rstn, .slow, .hold_wr, .fetch_req, .fetch_addr,
    .fetch_bytes, .ind_valid, .ind_ready, .ind_data, .wr_valid, .wr_ready);

  //////////////////////////////////////////////////////////////////////
  // compare and verdict
  task check(input logic [262:0] seen, input logic [262:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task tally_and_finish;
    if (mismatches == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // predicted registers, low slot first, zero padded
  task add_regs(input int n, input int base, input int tot, input bit ind,
                input logic [31:0] key);
    logic [255:0] d;
    for (int r = 0; r < (n + 7) / 8; r++) begin
      d = '0;
      for (int k = 0; k < 8; k++)
        if (r * 8 + k < n)
          d[32*k+:32] = ind ? {key[15:0], 16'(r * 8 + k)} : {8'hC0, key[7:0], 16'(r * 8 + k)};
      exp_q.push_back({1'(base + r == tot - 1), 6'(base + r), d});
    end
  endtask

  // one command dword, held until accepted
  task put_word(input logic [31:0] d);
    int t;
    cmd_valid = 1'b1;
    cmd_data  = d;
    t = 0;
    while (cmd_ready !== 1'b1 && t < 4000) begin
      @(posedge clk_sys);
      #1;
      t++;
    end
    // a buffer that never takes the word counts as a failure
    if (t >= 4000) mismatches++;
    @(posedge clk_sys);
    #1;
  endtask

  task send_cmd(input int n, input int nb, input logic [31:0] a);
    int ri, nd;
    ri = (n + 7) / 8;
    nd = (nb + 3) / 4;
    cmd_no++;
    add_regs(n, 0, ri + (nd + 7) / 8, 1'b0, {24'h0, cmd_no});
    add_regs(nd, ri, ri + (nd + 7) / 8, 1'b1, ind_base + a);
    if (nb != 0) fq.push_back({17'(nb), ind_base + a});
    put_word(32'(n + 2));
    put_word(32'h0);
    put_word(32'(nb));
    put_word(a);
    for (int k = 0; k < n; k++) put_word({8'hC0, cmd_no, 16'(k)});
  endtask

  task wait_idle;
    int t;
    cmd_valid = 1'b0;
    t = 0;
    while ((exp_q.size() != 0 || busy !== 1'b0) && t < 3000) begin
      @(posedge clk_sys);
      #1;
      t++;
    end
    if (t >= 3000) mismatches++;
    check(263'(exp_q.size()), 263'h0);
    check(263'(fq.size()), 263'h0);
    check(263'(busy), 263'h0);
  endtask

  //////////////////////////////////////////////////////////////////////
  // payload and fetch monitor
  always @(posedge clk_sys) begin
    if (rstn === 1'b1 && wr_valid === 1'b1 && wr_ready === 1'b1) begin
      e = (exp_q.size() != 0) ? exp_q.pop_front() : 'x;
      check({wr_last, wr_index, wr_data}, e);
    end
    if (rstn === 1'b1 && fetch_req === 1'b1) begin
      f = (fq.size() != 0) ? fq.pop_front() : 'x;
      check(263'({fetch_bytes, fetch_addr}), 263'(f));
    end
    if (cmd_ready === 1'b0) saw_full = 1'b1;
  end

  // clock and watchdog
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  initial begin
    repeat (40000) @(posedge clk_sys);
    mismatches++;
    tally_and_finish;
  end

  //////////////////////////////////////////////////////////////////////
  // test sequence; inline always present, addresses below 512MB
  initial begin
    rstn = 1'b0;
    {slow, hold_wr, saw_full, cmd_valid, cmd_no} = '0;
    mode = 2'b00;
    ind_base = 32'h0004_0000;
    cmd_data = 32'h0;
    mismatches = 0;
    samples_checked = 0;
    repeat (6) @(posedge clk_sys);
    #1;
    rstn = 1'b1;
    check(263'({cmd_ready, wr_valid, busy}), 263'h4);
    send_cmd(3, 0, 32'h0000_1230);
    send_cmd(8, 20, 32'h0000_2000);
    slow = 1'b1;
    send_cmd(16, 64, 32'h0000_3004);
    send_cmd(1, 4, 32'h0000_4008);
    wait_idle;
    hold_wr = 1'b1;
    fork
      send_cmd(40, 32, 32'h0000_5000);
      begin
        repeat (80) @(posedge clk_sys);
        #1;
        hold_wr = 1'b0;
      end
    join
    wait_idle;
    check(263'(saw_full), 263'h1);
    slow = 1'b0;
    mode = 2'b01;
    send_cmd(10, 12, 32'h0000_6004);
    wait_idle;
    check(263'(inl_ctrl), 263'({8'hC0, cmd_no, 16'h0}));
    mode = 2'b10;
    send_cmd(2, 5, 32'h0000_7003);
    wait_idle;
    check(263'(inl_ctrl), 263'({8'hC0, cmd_no, 16'h0}));
    tally_and_finish;
  end
endmodule
